// >>> src/nfct_cmd.sv
`timescale 1ns/1ps
// What this block does
// [R1] REQA only in idle, answer ATQA 0044h
// [R2] WUPA in idle or halt, answer ATQA
// [R3] level one commands only in Ready1
// [R4] level one anticollision returns UID part one
// [R5] level two commands only in Ready2
// [R6] level two anticollision returns UID part two
// [R7] level one select answers SAK 04h
// [R8] level two select answers SAK 00h
// [R9] select ignores a bad CRC
// [R10] cascade tag 88h leads segment one
// [R11] read beyond 29h answers ACK nibble
// [R12] read returns four pages, 16 bytes
// [R13] read wraps from page 29h to 00h
// [R14] halt enters halt state, silent
// [R15] halt works despite parity error
// [R16] write programs one page, ACK or NAK
// [R17] compatibility write keeps first four bytes
// [R18] reader zeroes unused compatibility bytes
// [R19] reader waits for compatibility acknowledges
// [R20] ACK Ah, NAK 1h integrity, 0h other
// [R21] any NAK resets the protocol state
// [R22] lock and CC bytes are OR-written
// [R23] compatibility write takes two phases
// [R24] selects advance to Ready2 then active
// [R25] misplaced commands go silent to idle, a halted tag stays in halt
module nfct_cmd
    import nfct_pkg::*;
#(
    parameter logic [55:0] P_UID = UID_DEFAULT // value arbitrary
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_rf_clk,
    input wire nfct_rx_t i_rx,
    input wire logic i_tx_ready,
    output nfct_tx_t o_tx,
    output logic o_tag_selected,
    output logic o_page_written
);
    // reset release copies, one per domain
    logic [1:0] core_rs_q;
    logic [1:0] rf_rs_q;
    logic core_rst_n;
    logic rf_rst_n;
    // protocol state
    nfct_state_t st_q, st_d;
    logic [7:0] buf_q [RX_MAX]; // frame bytes
    logic [7:0] buf_d [RX_MAX];
    logic [4:0] cnt_q, cnt_d; // bytes in frame
    logic perr_q, perr_d; // parity error seen
    logic cerr_q, cerr_d; // crc error seen
    logic [31:0] mem_q [NPAGES]; // tag pages
    logic [31:0] mem_d [NPAGES];
    logic [7:0] rsp_q [RSP_MAX]; // answer, head at 0
    logic [7:0] rsp_d [RSP_MAX];
    logic [4:0] len_q, len_d; // bytes left to send
    logic nib_q, nib_d; // answer is a nibble
    logic busy_q, busy_d;
    logic cw_q, cw_d; // waiting for compat data
    logic [5:0] cwpg_q, cwpg_d;
    logic wtog_q, wtog_d; // toggles per page write
    // core side crossing flops
    logic [2:0] wsync_q;
    logic [1:0] async_q;
    logic wpulse_q;
    // helpers for the frame decode
    logic go;
    logic perr;
    logic ierr;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [2:0] k;

    // byte i of UID segment for a cascade level
    function automatic logic [7:0] seg(input logic lvl, input logic [2:0] i);
        logic [7:0] b [5];
        if (!lvl) begin
            b[0] = CASC_TAG; // [R10]
            b[1] = P_UID[55:48];
            b[2] = P_UID[47:40];
            b[3] = P_UID[39:32];
        end else begin
            b[0] = P_UID[31:24];
            b[1] = P_UID[23:16];
            b[2] = P_UID[15:8];
            b[3] = P_UID[7:0];
        end
        b[4] = b[0] ^ b[1] ^ b[2] ^ b[3];
        return (i < 3'd5) ? b[i] : 8'h00;
    endfunction : seg

    // delivery image of the page array
    function automatic logic [31:0] pg_init(input int p);
        case (p)
            0: return {seg(1'b0, 3'd4), seg(1'b0, 3'd3), seg(1'b0, 3'd2), seg(1'b0, 3'd1)};
            1: return {seg(1'b1, 3'd3), seg(1'b1, 3'd2), seg(1'b1, 3'd1), seg(1'b1, 3'd0)};
            2: return {24'h00_0000, seg(1'b1, 3'd4)};
            3: return CC_INIT;
            4: return PG4_INIT;
            5: return PG5_INIT;
            default: return 32'h0000_0000;
        endcase
    endfunction : pg_init

    // page after a with wrap past the last page
    function automatic logic [5:0] wrap_pg(input logic [7:0] a, input logic [1:0] j);
        logic [6:0] s;
        s = {1'b0, a[5:0]} + {5'h00, j};
        if (s > {1'b0, PG_LAST[5:0]}) begin
            s = s - 7'(NPAGES); // [R13]
        end
        return s[5:0];
    endfunction : wrap_pg

    // merged page value; lock and CC bits only ever set
    function automatic logic [31:0] wr_val(input logic [5:0] pg, input logic [31:0] o,
                                           input logic [31:0] d);
        case (pg)
            PG_LOCK01: return {o[31:16] | d[31:16], o[15:0]}; // [R22]
            PG_CC: return o | d; // [R22]
            PG_LOCK23: return {o[31:16], o[15:0] | d[15:0]}; // [R22]
            default: return d;
        endcase
    endfunction : wr_val

    // reset release through two flops in each domain
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) core_rs_q <= 2'b00;
        else core_rs_q <= {core_rs_q[0], 1'b1};
    end
    always_ff @(posedge i_rf_clk or negedge i_resetn) begin
        if (!i_resetn) rf_rs_q <= 2'b00;
        else rf_rs_q <= {rf_rs_q[0], 1'b1};
    end
    assign core_rst_n = core_rs_q[1];
    assign rf_rst_n = rf_rs_q[1];

    assign go = i_rx.eof && !busy_q;
    assign perr = perr_q | i_rx.par_err;
    assign ierr = perr | cerr_q | i_rx.crc_err;
    assign c0 = buf_q[0];
    assign c1 = buf_q[1];
    assign k = c1[6:4] - 3'd2; // whole bytes already known

    // next state of the link side
    always_comb begin
        st_d = st_q;
        buf_d = buf_q;
        cnt_d = cnt_q;
        perr_d = perr;
        cerr_d = cerr_q | i_rx.crc_err;
        mem_d = mem_q;
        rsp_d = rsp_q;
        len_d = len_q;
        nib_d = nib_q;
        busy_d = busy_q;
        cw_d = cw_q;
        cwpg_d = cwpg_q;
        wtog_d = wtog_q;
        // collect frame bytes, extras dropped
        if (i_rx.valid && cnt_q < 5'(RX_MAX)) begin
            buf_d[cnt_q] = i_rx.data;
            cnt_d = cnt_q + 5'd1;
        end
        // answer drains one byte per accept
        if (busy_q && i_tx_ready) begin
            for (int i = 0; i < 15; i++) rsp_d[i] = rsp_q[i + 1];
            len_d = len_q - 5'd1;
            busy_d = (len_q != 5'd1);
        end
        // frames ending while an answer is out are dropped
        if (i_rx.eof) begin
            cnt_d = 5'd0;
            perr_d = 1'b0;
            cerr_d = 1'b0;
        end
        if (go) begin
            // anything unrecognised falls silent to idle, or stays in halt; a cascade code with a bad argument keeps its ready state
            st_d = (st_q == ST_HALT) ? ST_HALT : ST_IDLE; // [R25]
            cw_d = 1'b0;
            nib_d = 1'b0;
            if (i_rx.short_frame) begin
                if (c0[6:0] == CMD_REQA && st_q == ST_IDLE
                        || c0[6:0] == CMD_WUPA && st_q inside {ST_IDLE, ST_HALT}) begin
                    rsp_d[0] = ATQA_VAL[7:0]; // [R1] [R2]
                    rsp_d[1] = ATQA_VAL[15:8];
                    len_d = 5'd2;
                    busy_d = 1'b1;
                    st_d = ST_READY1;
                end
            end else if (cw_q && st_q == ST_ACTIVE) begin
                // second phase: 16 data bytes, first four kept
                busy_d = 1'b1; // [R23]
                len_d = 5'd1;
                nib_d = 1'b1;
                if (ierr) begin
                    rsp_d[0] = {4'h0, NAK_INTEG}; // [R20]
                end else if (cnt_q == CW_LEN) begin
                    mem_d[cwpg_q] = wr_val(cwpg_q, mem_q[cwpg_q],
                        {buf_q[3], buf_q[2], buf_q[1], buf_q[0]}); // [R17]
                    wtog_d = ~wtog_q;
                    rsp_d[0] = {4'h0, ACK_VAL};
                    st_d = ST_ACTIVE;
                end else begin
                    rsp_d[0] = {4'h0, NAK_OTHER}; // [R21]
                end
            end else if ((st_q == ST_READY1 && c0 == CMD_CL1)
                    || (st_q == ST_READY2 && c0 == CMD_CL2)) begin // [R3] [R5]
                st_d = st_q;
                if (c1 == ARG_SEL) begin
                    // crc flag deliberately not looked at
                    st_d = (st_q == ST_HALT) ? ST_HALT : ST_IDLE; // [R9]
                    if (cnt_q >= SEL_LEN) begin
                        st_d = (st_q == ST_READY1) ? ST_READY2 : ST_ACTIVE; // [R24]
                        for (int i = 0; i < 5; i++) begin
                            if (buf_q[i + 2] != seg(c0 == CMD_CL2, 3'(i))) st_d = ST_IDLE;
                        end
                    end
                    if (st_d != ST_IDLE) begin
                        rsp_d[0] = (st_q == ST_READY1) ? SAK_CL1 : SAK_CL2; // [R7] [R8]
                        len_d = 5'd1;
                        busy_d = 1'b1;
                    end
                end else if (c1 >= ARG_AC_MIN && c1 <= ARG_AC_MAX) begin
                    // rest of the segment; partial bits not honoured
                    for (int i = 0; i < 5; i++) begin
                        rsp_d[i] = seg(c0 == CMD_CL2, 3'(k + 3'(i))); // [R4] [R6]
                    end
                    len_d = 5'd5 - {2'b00, k};
                    busy_d = 1'b1;
                end
            end else if (st_q == ST_ACTIVE) begin
                if (c0 == CMD_HALT && c1 == ARG_HALT && !cerr_q && !i_rx.crc_err) begin
                    st_d = ST_HALT; // [R14] [R15]
                end else if (c0 inside {CMD_READ, CMD_WRITE, CMD_CWRITE}) begin
                    busy_d = 1'b1;
                    len_d = 5'd1;
                    nib_d = 1'b1;
                    rsp_d[0] = {4'h0, NAK_OTHER}; // [R20] [R21]
                    if (ierr) begin
                        rsp_d[0] = {4'h0, NAK_INTEG}; // [R20]
                    end else if (c0 == CMD_READ && c1 > PG_LAST) begin
                        rsp_d[0] = {4'h0, ACK_VAL}; // [R11]
                        st_d = ST_ACTIVE;
                    end else if (c0 == CMD_READ) begin
                        for (int j = 0; j < 4; j++) begin
                            for (int b = 0; b < 4; b++) begin
                                rsp_d[4 * j + b] = mem_q[wrap_pg(c1, 2'(j))][8 * b +: 8]; // [R12]
                            end
                        end
                        len_d = RSP_MAX;
                        nib_d = 1'b0;
                        st_d = ST_ACTIVE;
                    end else if (c1 >= PG_WR_MIN && c1 <= PG_LAST) begin
                        rsp_d[0] = {4'h0, ACK_VAL};
                        st_d = ST_ACTIVE;
                        if (c0 == CMD_CWRITE) begin
                            cw_d = 1'b1; // [R23]
                            cwpg_d = c1[5:0];
                        end else if (cnt_q == WR_LEN) begin
                            mem_d[c1[5:0]] = wr_val(c1[5:0], mem_q[c1[5:0]],
                                {buf_q[5], buf_q[4], buf_q[3], buf_q[2]}); // [R16]
                            wtog_d = ~wtog_q;
                        end else begin
                            rsp_d[0] = {4'h0, NAK_OTHER};
                            st_d = ST_IDLE;
                        end
                    end
                end
            end
        end
    end

    // link side registers
    always_ff @(posedge i_rf_clk or negedge rf_rst_n) begin
        if (!rf_rst_n) begin
            st_q <= ST_IDLE;
            cnt_q <= 5'd0;
            perr_q <= 1'b0;
            cerr_q <= 1'b0;
            len_q <= 5'd0;
            nib_q <= 1'b0;
            busy_q <= 1'b0;
            cw_q <= 1'b0;
            cwpg_q <= 6'h00;
            wtog_q <= 1'b0;
            for (int i = 0; i < RX_MAX; i++) buf_q[i] <= 8'h00;
            for (int i = 0; i < 16; i++) rsp_q[i] <= 8'h00;
            for (int i = 0; i < NPAGES; i++) mem_q[i] <= pg_init(i);
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            perr_q <= perr_d;
            cerr_q <= cerr_d;
            len_q <= len_d;
            nib_q <= nib_d;
            busy_q <= busy_d;
            cw_q <= cw_d;
            cwpg_q <= cwpg_d;
            wtog_q <= wtog_d;
            buf_q <= buf_d;
            rsp_q <= rsp_d;
            mem_q <= mem_d;
        end
    end

    // answer stream, data straight from flops
    assign o_tx.valid = busy_q;
    assign o_tx.data = rsp_q[0];
    assign o_tx.last = busy_q && len_q == 5'd1;
    assign o_tx.nibble = nib_q;

    // selected level and write toggle into the core domain
    always_ff @(posedge i_core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            async_q <= 2'b00;
            wsync_q <= 3'b000;
            wpulse_q <= 1'b0;
        end else begin
            async_q <= {async_q[0], st_q == ST_ACTIVE};
            wsync_q <= {wsync_q[1:0], wtog_q};
            wpulse_q <= wsync_q[2] ^ wsync_q[1];
        end
    end
    assign o_tag_selected = async_q[1];
    assign o_page_written = wpulse_q;

    property p_reqa;
        @(posedge i_rf_clk) disable iff (!rf_rst_n)
        go && i_rx.short_frame && c0[6:0] == CMD_REQA && st_q == ST_IDLE
            |=> st_q == ST_READY1 && len_q == 5'd2 && rsp_q[0] == 8'h44;
    endproperty
    a_reqa: assert property (p_reqa) else $error("reqa not answered"); // [R1]

    property p_wupa;
        @(posedge i_rf_clk) disable iff (!rf_rst_n)
        go && i_rx.short_frame && c0[6:0] == CMD_WUPA && st_q == ST_HALT
            |=> st_q == ST_READY1 && busy_q && len_q == 5'd2 && rsp_q[0] == 8'h44
                && rsp_q[1] == 8'h00;
    endproperty
    a_wupa: assert property (p_wupa) else $error("wupa from halt failed"); // [R2]

    property p_halt_deaf;
        @(posedge i_rf_clk) disable iff (!rf_rst_n)
        go && i_rx.short_frame && c0[6:0] == CMD_REQA && st_q == ST_HALT
            |=> st_q == ST_HALT && !busy_q;
    endproperty
    a_halt_deaf: assert property (p_halt_deaf) else $error("halted tag answered"); // [R14]

    property p_sel1;
        @(posedge i_rf_clk) disable iff (!rf_rst_n)
        go && st_q == ST_READY1 && c0 == CMD_CL1 && c1 == ARG_SEL ##1 st_q == ST_READY2
            |-> busy_q && rsp_q[0] == SAK_CL1 && len_q == 5'd1;
    endproperty
    a_sel1: assert property (p_sel1) else $error("level one sak wrong"); // [R7]

    property p_sel2;
        @(posedge i_rf_clk) disable iff (!rf_rst_n)
        go && st_q == ST_READY2 && c0 == CMD_CL2 && c1 == ARG_SEL ##1 st_q == ST_ACTIVE
            |-> busy_q && rsp_q[0] == SAK_CL2;
    endproperty
    a_sel2: assert property (p_sel2) else $error("level two sak wrong"); // [R8]

    property p_read;
        @(posedge i_rf_clk) disable iff (!rf_rst_n)
        go && st_q == ST_ACTIVE && !cw_q && c0 == CMD_READ && c1 <= PG_LAST && !ierr
            |=> len_q == RSP_MAX && !nib_q && st_q == ST_ACTIVE;
    endproperty
    a_read: assert property (p_read) else $error("read length wrong"); // [R12]

    property p_nak_reset;
        @(posedge i_rf_clk) disable iff (!rf_rst_n)
        busy_q && nib_q && rsp_q[0][3:0] != ACK_VAL |-> st_q != ST_ACTIVE;
    endproperty
    a_nak_reset: assert property (p_nak_reset) else $error("nak left tag active"); // [R21]

    property p_halt_par;
        @(posedge i_rf_clk) disable iff (!rf_rst_n)
        go && st_q == ST_ACTIVE && !cw_q && c0 == CMD_HALT && c1 == ARG_HALT && perr
            && !cerr_q && !i_rx.crc_err |=> st_q == ST_HALT && !busy_q [*2];
    endproperty
    a_halt_par: assert property (p_halt_par) else $error("halt refused on parity"); // [R15]

    property p_stray;
        @(posedge i_rf_clk) disable iff (!rf_rst_n)
        go && !i_rx.short_frame && st_q == ST_IDLE |=> st_q == ST_IDLE && !busy_q;
    endproperty
    a_stray: assert property (p_stray) else $error("idle tag reacted"); // [R25]
endmodule : nfct_cmd

// >>> src/nfct_pkg.sv
package nfct_pkg;
    // short frame codes (7-bit)
    localparam logic [6:0] CMD_REQA = 7'h26;
    localparam logic [6:0] CMD_WUPA = 7'h52;
    // standard frame codes and parameters
    localparam logic [7:0] CMD_CL1 = 8'h93;
    localparam logic [7:0] CMD_CL2 = 8'h95;
    localparam logic [7:0] ARG_SEL = 8'h70;
    localparam logic [7:0] ARG_AC_MIN = 8'h20;
    localparam logic [7:0] ARG_AC_MAX = 8'h67;
    localparam logic [7:0] CMD_READ = 8'h30;
    localparam logic [7:0] CMD_HALT = 8'h50;
    localparam logic [7:0] ARG_HALT = 8'h00;
    localparam logic [7:0] CMD_WRITE = 8'hA2;
    localparam logic [7:0] CMD_CWRITE = 8'hA0;
    // answers
    localparam logic [7:0] CASC_TAG = 8'h88;
    localparam logic [7:0] SAK_CL1 = 8'h04;
    localparam logic [7:0] SAK_CL2 = 8'h00;
    localparam logic [15:0] ATQA_VAL = 16'h0044;
    localparam logic [3:0] ACK_VAL = 4'hA;
    localparam logic [3:0] NAK_INTEG = 4'h1;
    localparam logic [3:0] NAK_OTHER = 4'h0;
    // page map
    localparam logic [7:0] PG_LAST = 8'h29;
    localparam logic [7:0] PG_WR_MIN = 8'h02;
    localparam logic [5:0] PG_LOCK01 = 6'h02;
    localparam logic [5:0] PG_CC = 6'h03;
    localparam logic [5:0] PG_LOCK23 = 6'h28;
    localparam int NPAGES = 42;
    localparam logic [31:0] CC_INIT = 32'h0012_10E1;
    localparam logic [31:0] PG4_INIT = 32'h10A0_0301;
    localparam logic [31:0] PG5_INIT = 32'hFE00_0344;
    // frame sizes
    localparam int RX_MAX = 18;
    localparam logic [4:0] RSP_MAX = 5'h10;
    localparam logic [4:0] SEL_LEN = 5'h07;
    localparam logic [4:0] WR_LEN = 5'h06;
    localparam logic [4:0] CW_LEN = 5'h10;
    // serial number, value arbitrary
    localparam logic [55:0] UID_DEFAULT = 56'h5A_1234_5678_9ABC;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_READY1 = 5'h02,
        ST_READY2 = 5'h04,
        ST_ACTIVE = 5'h08,
        ST_HALT = 5'h10
    } nfct_state_t;
    // received byte stream from the frame decoder
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic eof;
        logic short_frame;
        logic par_err;
        logic crc_err;
    } nfct_rx_t;
    // answer stream to the frame encoder
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
        logic nibble;
    } nfct_tx_t;
endpackage : nfct_pkg

// >>> verification/nfct_reader.sv
`timescale 1ns/1ps
// reader model: frames out on the link, answers collected with optional stalls
module nfct_reader
    import nfct_pkg::*;
(
    input wire logic i_rf_clk,
    input wire nfct_tx_t i_tx,
    output nfct_rx_t o_rx,
    output logic o_tx_ready
);
    logic [7:0] ans[$]; // answer bytes of the last exchange
    logic ans_nib; // answer came as a 4-bit code
    int stall = 0; // nonzero: ready only every other cycle
    // quiet link at time zero
    initial begin
        o_rx = '0;
        o_tx_ready = 1'b0;
    end
    // bytes back to back, then the end mark with its qualifiers
    task automatic send(input logic [7:0] b[$], input logic sf, input logic pe, input logic ce);
        foreach (b[i]) begin
            @(negedge i_rf_clk);
            o_rx = '{valid: 1'b1, data: b[i], default: 1'b0};
        end
        @(negedge i_rf_clk);
        // data is meaningless off a strobe, so the end mark never repeats the last byte
        o_rx = '{valid: 1'b0, data: ~o_rx.data, eof: 1'b1, short_frame: sf,
            par_err: pe, crc_err: ce};
        @(negedge i_rf_clk);
        o_rx = '{valid: 1'b0, data: ~o_rx.data, default: 1'b0};
    endtask : send
    // collect one answer; a bounded wait stands in for the reader's timeout
    task automatic recv(input int limit, output logic got);
        int n;
        ans.delete();
        got = 1'b0;
        n = 0;
        while (!got && n < limit) begin
            @(negedge i_rf_clk);
            o_tx_ready = (stall != 0) ? n[0] : 1'b1;
            #1;
            // byte leaves at the next rising edge
            if (i_tx.valid === 1'b1 && o_tx_ready) begin
                ans.push_back(i_tx.data);
                ans_nib = i_tx.nibble;
                got = (i_tx.last === 1'b1);
            end
            n++;
        end
        @(negedge i_rf_clk);
        o_tx_ready = 1'b0;
    endtask : recv
endmodule : nfct_reader

// >>> verification/tb_nfc_type2_tag_command_set.sv
`timescale 1ns/1ps
// bench for the tag command interpreter
module tb_nfc_type2_tag_command_set;
    import nfct_pkg::*;
    localparam logic [55:0] UID = 56'h11_2233_4455_6677; // value arbitrary
    localparam logic [7:0] BCC0 = 8'h88 ^ 8'h11 ^ 8'h22 ^ 8'h33;
    localparam logic [7:0] BCC1 = 8'h44 ^ 8'h55 ^ 8'h66 ^ 8'h77;
    logic core_clk = 1'b0; // 25 MHz
    logic rf_clk = 1'b0; // link clock, 6 ns
    logic resetn = 1'b0; // active low
    nfct_rx_t rx; // reader to tag
    nfct_tx_t tx; // tag to reader
    logic tx_ready; // reader accepts
    logic tag_sel; // active state, core domain
    logic pg_wr; // page program pulse
    logic got; // answer seen
    int fails = 0;
    int checks = 0;
    int cycles = 0; // hang guard
    int pw_cnt = 0; // program pulses seen
    // clocks, link offset so phases never line up
    always #20 core_clk = ~core_clk;
    initial begin
        #1.7;
        forever #3 rf_clk = ~rf_clk;
    end
    nfct_cmd #(.P_UID(UID)) i_dut (.i_core_clk(core_clk), .i_resetn(resetn),
        .i_rf_clk(rf_clk), .i_rx(rx), .i_tx_ready(tx_ready), .o_tx(tx),
        .o_tag_selected(tag_sel), .o_page_written(pg_wr));
    nfct_reader i_rdr (.i_rf_clk(rf_clk), .i_tx(tx), .o_rx(rx), .o_tx_ready(tx_ready));
    // count program pulses; one per page written
    always @(posedge core_clk) begin
        if (pg_wr === 1'b1) begin
            pw_cnt++;
        end
    end
    // compare and report
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one exchange: frame out, answer back
    task automatic xfer(input logic [7:0] b[$], input logic sf, input logic pe, input logic ce);
        i_rdr.send(b, sf, pe, ce);
        i_rdr.recv(60, got);
    endtask : xfer
    // whole answer against a list
    task automatic expect_ans(input string what, input logic [7:0] e[$]);
        check({what, " len"}, 32'(i_rdr.ans.size()), 32'(e.size()));
        foreach (e[i]) check(what, 32'(i_rdr.ans[i]), 32'(e[i]));
    endtask : expect_ans
    // wake and run both cascade levels, selects with a bad crc
    task automatic activate(input logic [7:0] wake);
        xfer('{wake}, 1'b1, 1'b0, 1'b0);
        expect_ans("atqa", '{8'h44, 8'h00});
        xfer('{CMD_CL1, 8'h20}, 1'b0, 1'b0, 1'b0);
        expect_ans("uid one", '{8'h88, 8'h11, 8'h22, 8'h33, BCC0});
        xfer('{CMD_CL1, 8'h40, 8'h88, 8'h11}, 1'b0, 1'b0, 1'b0);
        expect_ans("uid one rest", '{8'h22, 8'h33, BCC0});
        xfer('{CMD_CL1, ARG_SEL, 8'h88, 8'h11, 8'h22, 8'h33, BCC0}, 1'b0, 1'b0, 1'b1);
        expect_ans("sak one", '{8'h04});
        xfer('{CMD_CL2, 8'h20}, 1'b0, 1'b0, 1'b0);
        expect_ans("uid two", '{8'h44, 8'h55, 8'h66, 8'h77, BCC1});
        xfer('{CMD_CL2, ARG_SEL, 8'h44, 8'h55, 8'h66, 8'h77, BCC1}, 1'b0, 1'b0, 1'b1);
        expect_ans("sak two", '{8'h00});
    endtask : activate
    // commands out of their state are ignored and drop the tag to idle
    task automatic t_gating();
        xfer('{CMD_CL1, 8'h20}, 1'b0, 1'b0, 1'b0);
        check("idle cl1", 32'(got), 0);
        xfer('{8'h26}, 1'b1, 1'b0, 1'b0);
        expect_ans("reqa", '{8'h44, 8'h00});
        xfer('{CMD_CL2, 8'h20}, 1'b0, 1'b0, 1'b0);
        check("ready1 cl2", 32'(got), 0);
        xfer('{8'h26}, 1'b1, 1'b0, 1'b0);
        expect_ans("reqa again", '{8'h44, 8'h00});
        xfer('{8'h26}, 1'b1, 1'b0, 1'b0);
        check("ready1 reqa", 32'(got), 0);
    endtask : t_gating
    // selection reaches the core side
    task automatic t_select();
        activate(8'h52);
        repeat (4) @(posedge core_clk);
        check("selected", 32'(tag_sel), 1);
    endtask : t_select
    // reads: four pages, wrap, out of range code; stalls on the first
    task automatic t_read();
        i_rdr.stall = 1;
        xfer('{CMD_READ, 8'h03}, 1'b0, 1'b0, 1'b0);
        expect_ans("read 03h", '{8'hE1, 8'h10, 8'h12, 8'h00, 8'h01, 8'h03, 8'hA0, 8'h10,
            8'h44, 8'h03, 8'h00, 8'hFE, 8'h00, 8'h00, 8'h00, 8'h00});
        i_rdr.stall = 0;
        xfer('{CMD_READ, 8'h29}, 1'b0, 1'b0, 1'b0);
        check("wrap len", 32'(i_rdr.ans.size()), 16);
        check("wrap 00h", {i_rdr.ans[7], i_rdr.ans[6], i_rdr.ans[5], i_rdr.ans[4]},
            {BCC0, 8'h33, 8'h22, 8'h11});
        check("wrap 01h", {i_rdr.ans[11], i_rdr.ans[10], i_rdr.ans[9], i_rdr.ans[8]},
            32'h7766_5544);
        xfer('{CMD_READ, 8'h2A}, 1'b0, 1'b0, 1'b0);
        check("read 2Ah", {i_rdr.ans_nib, i_rdr.ans[0][3:0]}, {1'b1, 4'hA});
    endtask : t_read
    // plain write, lock or-merge, two-phase compatibility write
    task automatic t_write();
        logic [7:0] d[$];
        xfer('{CMD_WRITE, 8'h04, 8'hDE, 8'hAD, 8'hBE, 8'hEF}, 1'b0, 1'b0, 1'b0);
        check("write ack", {i_rdr.ans_nib, i_rdr.ans[0][3:0]}, {1'b1, 4'hA});
        xfer('{CMD_WRITE, 8'h02, 8'h00, 8'h00, 8'h0F, 8'hF0}, 1'b0, 1'b0, 1'b0);
        xfer('{CMD_WRITE, 8'h02, 8'h00, 8'h00, 8'h30, 8'h03}, 1'b0, 1'b0, 1'b0);
        xfer('{CMD_CWRITE, 8'h05}, 1'b0, 1'b0, 1'b0);
        check("cw phase one", {i_rdr.ans_nib, i_rdr.ans[0][3:0]}, {1'b1, 4'hA});
        d = '{8'h11, 8'h22, 8'h33, 8'h44};
        repeat (12) d.push_back(8'h00);
        xfer(d, 1'b0, 1'b0, 1'b0);
        check("cw phase two", {i_rdr.ans_nib, i_rdr.ans[0][3:0]}, {1'b1, 4'hA});
        xfer('{CMD_READ, 8'h02}, 1'b0, 1'b0, 1'b0);
        check("lock merge", {i_rdr.ans[3], i_rdr.ans[2]}, 16'hF33F);
        check("page 04h", {i_rdr.ans[11], i_rdr.ans[10], i_rdr.ans[9], i_rdr.ans[8]},
            32'hEFBE_ADDE);
        check("page 05h", {i_rdr.ans[15], i_rdr.ans[14], i_rdr.ans[13], i_rdr.ans[12]},
            32'h4433_2211);
        xfer('{CMD_READ, 8'h06}, 1'b0, 1'b0, 1'b0);
        check("page 06h", {i_rdr.ans[3], i_rdr.ans[2], i_rdr.ans[1], i_rdr.ans[0]}, 0);
        repeat (6) @(posedge core_clk);
        check("page programs", pw_cnt, 4);
    endtask : t_write
    // refused writes: code 0h or 1h, then the tag has fallen back to idle
    task automatic t_nak();
        xfer('{CMD_WRITE, 8'h01, 8'h12, 8'h34, 8'h56, 8'h78}, 1'b0, 1'b0, 1'b0);
        check("nak range", {i_rdr.ans_nib, i_rdr.ans[0][3:0]}, {1'b1, 4'h0});
        xfer('{CMD_READ, 8'h04}, 1'b0, 1'b0, 1'b0);
        check("after nak", 32'(got), 0);
        activate(8'h26);
        xfer('{CMD_WRITE, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78}, 1'b0, 1'b0, 1'b1);
        check("nak crc", {i_rdr.ans_nib, i_rdr.ans[0][3:0]}, {1'b1, 4'h1});
        xfer('{CMD_READ, 8'h04}, 1'b0, 1'b0, 1'b0);
        check("after nak crc", 32'(got), 0);
        repeat (6) @(posedge core_clk);
        check("no programs", pw_cnt, 4);
    endtask : t_nak
    // halt with a parity slip, only the wake-up code gets through
    task automatic t_halt();
        activate(8'h26);
        xfer('{CMD_HALT, ARG_HALT}, 1'b0, 1'b1, 1'b0);
        check("halt silent", 32'(got), 0);
        repeat (4) @(posedge core_clk);
        check("halt unselected", 32'(tag_sel), 0);
        xfer('{8'h26}, 1'b1, 1'b0, 1'b0);
        check("halt reqa", 32'(got), 0);
        xfer('{CMD_READ, 8'h00}, 1'b0, 1'b0, 1'b0);
        check("halt read", 32'(got), 0);
        xfer('{8'h52}, 1'b1, 1'b0, 1'b0);
        expect_ans("halt wupa", '{8'h44, 8'h00});
    endtask : t_halt
    // verdict, the one place the run ends
    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    // hang guard, far above the some 170 core cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end
    // main sequence
    initial begin
        repeat (12) @(negedge core_clk);
        resetn = 1'b1;
        // both synchronisers must let go before the first frame
        repeat (4) @(negedge core_clk);
        t_gating();
        t_select();
        t_read();
        t_write();
        t_nak();
        t_halt();
        finish_test();
    end
endmodule : tb_nfc_type2_tag_command_set
